// *** cps_regs.svh ***
`ifndef CPS_REGS_SVH
`define CPS_REGS_SVH
`define CPS_CLK_MHZ 200
`define CPS_RESET_TIME_MS 1
`define CPS_VALID_LOW_RST_NS 300
`define CPS_VALID_LOW_RST_CYC ((`CPS_VALID_LOW_RST_NS * `CPS_CLK_MHZ) / 1000)
`define CPS_I2C_READY_US 3500
`define CPS_I2C_READY_CYC (`CPS_I2C_READY_US * `CPS_CLK_MHZ)
`define CPS_RUN_MS 10
`define CPS_RUN_CYC (`CPS_RUN_MS * 1000 * `CPS_CLK_MHZ)
`define CPS_PDN_MIN_NS 800
`define CPS_PDN_MIN_CYC ((`CPS_PDN_MIN_NS * `CPS_CLK_MHZ + 999) / 1000)
`define CPS_PDN_VALID_US 725
`define CPS_PDN_VALID_CYC (`CPS_PDN_VALID_US * `CPS_CLK_MHZ)
`define CPS_FAULT_MIN_NS 350
`define CPS_FAULT_MIN_CYC ((`CPS_FAULT_MIN_NS * `CPS_CLK_MHZ + 999) / 1000)
`define CPS_FAULT_LOW_NS 350
`define CPS_FAULT_LOW_CYC ((`CPS_FAULT_LOW_NS * `CPS_CLK_MHZ) / 1000)
`define CPS_HEADPHONE_SELECT_MIN_NS 350
`define CPS_HEADPHONE_SELECT_MIN_CYC ((`CPS_HEADPHONE_SELECT_MIN_NS * `CPS_CLK_MHZ + 999) / 1000)
`define CPS_RAMP_STEPS_RST 16'h0400
`define CPS_STEP_LR_NORMAL 4
`define CPS_STEP_LR_DOUBLE 8
`define CPS_STEP_LR_QUAD 16
`define CPS_HP_DISABLE_BIT 4
`endif

// *** cps_pkg.sv ***
package cps_pkg;
	typedef enum logic [1:0] {CPS_RATE_NORMAL, CPS_RATE_DOUBLE, CPS_RATE_QUAD}
		cps_rate_t;
	typedef enum {CPS_ST_RESET, CPS_ST_WAIT_I2C, CPS_ST_IDLE, CPS_ST_START,
		CPS_ST_RUN, CPS_ST_PDN_DRAIN, CPS_ST_DOWN} cps_state_t;
	typedef enum {CPS_F_OK, CPS_F_HOLD} cps_fault_t;
	// Configuration values that the control port hands to this block.
	typedef struct packed {
		logic [15:0] ramp_steps;
		logic [15:0] fault_hold_cyc;
		logic [7:0] hp_config;
		cps_rate_t rate;
	} cps_cfg_t;
	// Status reported back to the control port.
	typedef struct packed {
		logic i2c_ready;
		logic running;
		logic ramp_busy;
		logic fault_active;
	} cps_stat_t;
endpackage

// *** cps_control_pin_sequencer.sv ***
`timescale 1ns/1ps
`include "cps_regs.svh"
// What this block and the parts driving its pins must do
// RULE_01: Controller holds reset low about 1 ms for a valid reset.
// RULE_02: Reset drives power-stage enable low within about 300 ns.
// RULE_03: Control port usable only 3.5 ms after reset release.
// RULE_04: After start-up command allow at least 10 ms before normal run.
// RULE_05: Controller holds power-down low at least 800 ns to register.
// RULE_06: Power-down drops power-stage enable after about 725 us.
// RULE_07: Power stage reports fault by driving fault low at least 350 ns.
// RULE_08: Within 350 ns of fault, all speaker PWM outputs forced low.
// RULE_09: Hold forced-low for programmed time, resume only if fault cleared.
// RULE_10: Mute ramp lasts programmed steps times step size, default 1024.
// RULE_11: Ramp step is 4, 8 or 16 frame clocks per rate group.
// RULE_12: Controller holds headphone-select at least 350 ns for a change.
// RULE_13: With config bit 4 set, headphone select low disables HEADPHONE_PWM_OUT.
// RULE_14: Power-stage enable stays low until start-up sequence completes.
module cps_control_pin_sequencer
	import cps_pkg::*;
#(
	parameter int I2C_READY_CYC = `CPS_I2C_READY_CYC,
	parameter int RUN_CYC = `CPS_RUN_CYC,
	parameter int PDN_VALID_CYC = `CPS_PDN_VALID_CYC
)(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic power_down_n,
	input wire logic backend_fault_n,
	input wire logic headphone_select,
	input wire logic mute,
	input wire logic lrclk_tick,
	input wire logic startup_cmd,
	input wire cps_cfg_t cfg,
	output logic power_stage_valid,
	output logic speaker_pwm_enable,
	output logic headphone_pwm_out,
	output logic [15:0] volume_step,
	output cps_stat_t status
);
	localparam int CW = 32;
	cps_state_t state;
	cps_fault_t fstate;
	logic [CW-1:0] tmr;
	logic [7:0] pdn_cnt;
	logic [7:0] flt_cnt;
	logic [7:0] hp_cnt;
	logic pdn_req;
	logic fault_seen;
	logic hp_sel;
	logic [15:0] fhold;
	logic [4:0] lr_cnt;
	logic [4:0] step_len;
	logic fault_now;

	// Power-down is taken only after it stays low for the minimum width.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			pdn_cnt <= 8'h00;
		else if (power_down_n)
			pdn_cnt <= 8'h00;
		else if (pdn_cnt < 8'(`CPS_PDN_MIN_CYC)) // RULE_05
			pdn_cnt <= pdn_cnt + 8'h01;
	end
	assign pdn_req = (pdn_cnt >= 8'(`CPS_PDN_MIN_CYC)); // RULE_05

	// Main sequence; reset forces the enable low asynchronously.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= CPS_ST_RESET;
			tmr <= '0;
		end
		else if (pdn_req && state != CPS_ST_PDN_DRAIN && state != CPS_ST_DOWN)
		begin
			state <= CPS_ST_PDN_DRAIN;
			tmr <= '0;
		end
		else
		begin
			tmr <= tmr + 1'b1;
			unique case (state)
				CPS_ST_RESET:
				begin
					state <= CPS_ST_WAIT_I2C;
					tmr <= '0;
				end
				CPS_ST_WAIT_I2C:
					if (tmr >= CW'(I2C_READY_CYC - 1)) // RULE_03
						state <= CPS_ST_IDLE;
				CPS_ST_IDLE:
					if (startup_cmd)
					begin
						state <= CPS_ST_START;
						tmr <= '0;
					end
				CPS_ST_START:
					if (tmr >= CW'(RUN_CYC - 1)) // RULE_04
						state <= CPS_ST_RUN;
				CPS_ST_RUN:
					tmr <= '0;
				CPS_ST_PDN_DRAIN:
					if (tmr >= CW'(PDN_VALID_CYC - 1)) // RULE_06
						state <= CPS_ST_DOWN;
				CPS_ST_DOWN:
					if (power_down_n)
					begin
						state <= CPS_ST_IDLE;
						tmr <= '0;
					end
			endcase
		end
	end

	// Enable is high only in run or while power-down drains out.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			power_stage_valid <= 1'b0; // RULE_02
		else
			power_stage_valid <= (state == CPS_ST_RUN) || // RULE_14
				(state == CPS_ST_PDN_DRAIN && power_stage_valid); // RULE_06
	end

	// Fault filter: a glitch sampled low at fewer than two clock edges is ignored.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			flt_cnt <= 8'h00;
		else if (backend_fault_n)
			flt_cnt <= 8'h00;
		else if (flt_cnt < 8'(`CPS_FAULT_MIN_CYC)) // RULE_07
			flt_cnt <= flt_cnt + 8'h01;
	end
	// Acting one cycle into the fault keeps the output drop well inside 350 ns.
	assign fault_now = !backend_fault_n && flt_cnt >= 8'h01; // RULE_08
	assign fault_seen = fault_now;

	// Fault hold: speaker outputs stay low for the programmed time, then retry.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			fstate <= CPS_F_OK;
			fhold <= 16'h0000;
		end
		else
			unique case (fstate)
				CPS_F_OK:
					if (fault_seen)
					begin
						fstate <= CPS_F_HOLD; // RULE_08
						fhold <= 16'h0000;
					end
				CPS_F_HOLD:
					if (fhold < cfg.fault_hold_cyc)
						fhold <= fhold + 16'h0001;
					else if (backend_fault_n)
						fstate <= CPS_F_OK; // RULE_09
			endcase
	end

	// Speaker outputs run only in normal operation and outside a fault.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			speaker_pwm_enable <= 1'b0;
		else
			speaker_pwm_enable <= (state == CPS_ST_RUN) && !fault_seen &&
				(fstate == CPS_F_OK); // RULE_08
	end

	// Step length in frame clocks picked from the sample-rate group.
	always_comb
	begin
		unique case (cfg.rate)
			CPS_RATE_DOUBLE: step_len = 5'(`CPS_STEP_LR_DOUBLE); // RULE_11
			CPS_RATE_QUAD: step_len = 5'(`CPS_STEP_LR_QUAD); // RULE_11
			default: step_len = 5'(`CPS_STEP_LR_NORMAL); // RULE_11
		endcase
	end

	// Volume ramp: one step every step_len frame clocks toward the target.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			lr_cnt <= 5'h00;
			volume_step <= 16'h0000;
		end
		else if (lrclk_tick)
		begin
			if (lr_cnt >= step_len - 5'h01)
			begin
				lr_cnt <= 5'h00;
				if (mute && volume_step != 16'h0000)
					volume_step <= volume_step - 16'h0001; // RULE_10
				else if (!mute && volume_step < cfg.ramp_steps)
					volume_step <= volume_step + 16'h0001; // RULE_10
				else if (volume_step > cfg.ramp_steps)
					volume_step <= cfg.ramp_steps;
			end
			else
				lr_cnt <= lr_cnt + 5'h01;
		end
	end

	// Headphone select is taken only after it is steady for the minimum width.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			hp_cnt <= 8'h00;
			hp_sel <= 1'b0;
		end
		else if (headphone_select == hp_sel)
			hp_cnt <= 8'h00;
		else if (hp_cnt >= 8'(`CPS_HEADPHONE_SELECT_MIN_CYC - 1)) // RULE_12
		begin
			hp_sel <= headphone_select;
			hp_cnt <= 8'h00;
		end
		else
			hp_cnt <= hp_cnt + 8'h01;
	end

	// Headphone line output gated by select only when config bit 4 is set.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			headphone_pwm_out <= 1'b0;
		else
			headphone_pwm_out <= (state == CPS_ST_RUN) &&
				(hp_sel || !cfg.hp_config[`CPS_HP_DISABLE_BIT]); // RULE_13
	end

	// Status flags for the control port.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			status <= '0;
		else
		begin
			status.i2c_ready <= (state != CPS_ST_RESET) &&
				(state != CPS_ST_WAIT_I2C); // RULE_03
			status.running <= (state == CPS_ST_RUN);
			status.ramp_busy <= mute ? (volume_step != 16'h0000) :
				(volume_step != cfg.ramp_steps);
			status.fault_active <= (fstate == CPS_F_HOLD);
		end
	end

	reset_low_a: assert property (@(posedge clk_sys) // RULE_02
		!resetn |=> !power_stage_valid)
		else $error("enable high after reset");
	i2c_wait_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_03
		$rose(status.i2c_ready) && $past(state) == CPS_ST_IDLE |->
		$past(tmr) >= CW'(I2C_READY_CYC))
		else $error("control port ready too early");
	start_wait_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_04
		(state == CPS_ST_IDLE && startup_cmd && !pdn_req) |=>
		state == CPS_ST_START [*8])
		else $error("start-up interval cut short");
	pdn_width_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_05
		$rose(pdn_req) |-> !$past(power_down_n))
		else $error("power-down taken without low input");
	pdn_drop_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_06
		(state == CPS_ST_DOWN) |=> !power_stage_valid)
		else $error("enable high after power-down");
	fault_drop_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_08
		(!backend_fault_n [*2]) |=> !speaker_pwm_enable)
		else $error("speaker outputs not forced low");
	fault_resume_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_09
		(fstate == CPS_F_HOLD && !backend_fault_n) |=> fstate == CPS_F_HOLD)
		else $error("resumed with fault present");
	ramp_step_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_11
		(volume_step != $past(volume_step)) |-> $past(lrclk_tick))
		else $error("ramp step without frame tick");
	hp_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_13
		(cfg.hp_config[`CPS_HP_DISABLE_BIT] && !hp_sel) |=> !headphone_pwm_out)
		else $error("headphone output not disabled");
	enable_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_14
		$rose(power_stage_valid) |-> $past(state) == CPS_ST_RUN)
		else $error("enable before start-up done");
	run_c: cover property (@(posedge clk_sys) disable iff (!resetn)
		$rose(power_stage_valid));
	fault_c: cover property (@(posedge clk_sys) disable iff (!resetn)
		fstate == CPS_F_HOLD ##1 fstate == CPS_F_OK);
	pdn_c: cover property (@(posedge clk_sys) disable iff (!resetn)
		state == CPS_ST_DOWN);
endmodule

// *** cps_far_side.sv ***
`timescale 1ns/1ps
// Power stage and the controller's power-down pin; both idle high.
module cps_far_side (
	input wire logic clk_sys,
	output logic power_down_n,
	output logic backend_fault_n
);
	initial
	begin
		power_down_n = 1'b1;
		backend_fault_n = 1'b1;
	end
	// Reports keep the 350 ns minimum width, so the width is never under 70 cycles.
	task automatic report_fault(input int len);
		@(posedge clk_sys);
		#1 backend_fault_n = 1'b0;
		repeat ((len < 70) ? 70 : len) @(posedge clk_sys);
		#1 backend_fault_n = 1'b1;
	endtask
	// A request is held at least 160 cycles so that it is recognised.
	task automatic request_power_down(input int len);
		@(posedge clk_sys);
		#1 power_down_n = 1'b0;
		repeat ((len < 160) ? 160 : len) @(posedge clk_sys);
		#1 power_down_n = 1'b1;
	endtask
endmodule

// *** cps_control_pin_sequencer_tb_top.sv ***
`timescale 1ns/1ps
module cps_control_pin_sequencer_tb_top;
	import cps_pkg::*;
	localparam int I2C = 20, RUN = 50, POWER_DOWN_N = 30, STEPS = 3;
	logic clk_sys = 1'b0, resetn = 1'b0, headphone_select = 1'b1;
	logic mute = 1'b1, lrclk_tick = 1'b0, startup_cmd = 1'b0;
	logic power_down_n, backend_fault_n;
	logic power_stage_valid, speaker_pwm_enable, headphone_pwm_out;
	logic [15:0] volume_step;
	cps_cfg_t cfg = '{16'h0003, 16'h0028, 8'h10, CPS_RATE_NORMAL};
	cps_stat_t status;
	int errors = 0, samples_checked = 0, n, lo;
	cps_far_side i_cps_far_side (.clk_sys(clk_sys),
		.power_down_n(power_down_n), .backend_fault_n(backend_fault_n));
	cps_control_pin_sequencer #(.I2C_READY_CYC(I2C), .RUN_CYC(RUN),
		.PDN_VALID_CYC(POWER_DOWN_N)) i_cps_control_pin_sequencer (
		.clk_sys(clk_sys), .resetn(resetn), .power_down_n(power_down_n),
		.backend_fault_n(backend_fault_n), .headphone_select(headphone_select),
		.mute(mute), .lrclk_tick(lrclk_tick), .startup_cmd(startup_cmd),
		.cfg(cfg), .power_stage_valid(power_stage_valid),
		.speaker_pwm_enable(speaker_pwm_enable),
		.headphone_pwm_out(headphone_pwm_out), .volume_step(volume_step),
		.status(status));
	// Clock and a frame tick on every other cycle.
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) lrclk_tick <= #1 ~lrclk_tick;
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic pick(input int w);
		case (w)
			0: return power_stage_valid;
			1: return speaker_pwm_enable;
			2: return headphone_pwm_out;
			default: return status.i2c_ready;
		endcase
	endfunction
	// Counts cycles until the chosen output reaches val; a hang ends the run.
	task automatic wait_on(input int w, input logic val, input int bound);
		n = 0;
		while (pick(w) !== val)
		begin
			@(posedge clk_sys);
			#1 n++;
			if (n > bound)
			begin
				errors++;
				$display("BAD wait %0d expected %b seen %b", w, val, pick(w));
				print_verdict();
			end
		end
	endtask
	task automatic t_start();
		@(posedge clk_sys);
		#1 startup_cmd = 1'b1;
		@(posedge clk_sys);
		#1 startup_cmd = 1'b0;
		check("valid early", 1'b0, power_stage_valid);
		wait_on(0, 1'b1, RUN + 10);
		check("run delay", 1'b1, n >= RUN - 2 && n <= RUN + 2);
		check("running", 1'b1, status.running);
		$display("start done");
	endtask
	// Each rate group in turn, ramping up, down, then up again.
	task automatic t_ramp();
		for (int r = 0; r < 3; r++)
		begin
			cfg.rate = cps_rate_t'(r);
			mute = (r == 1);
			lo = 0;
			while (volume_step !== (mute ? 16'h0000 : 16'h0003) && lo < 400)
			begin
				@(posedge clk_sys);
				#1 lo++;
			end
			check("ramp", 1'b1, lo > 2 * (STEPS - 1) * (4 << r)
				&& lo <= 2 * STEPS * (4 << r) + 4);
			if (lo >= 400)
				print_verdict();
		end
		@(posedge clk_sys);
		#1 check("ramp busy", 1'b0, status.ramp_busy);
		$display("ramp done");
	endtask
	task automatic t_fault();
		check("spk before", 1'b1, speaker_pwm_enable);
		fork
			i_cps_far_side.report_fault(100);
			begin
				@(posedge clk_sys);
				#2 wait_on(1, 1'b0, 3);
				repeat (60) @(posedge clk_sys);
				#1 check("spk held", 1'b0, speaker_pwm_enable);
				check("fault flag", 1'b1, status.fault_active);
			end
		join
		wait_on(1, 1'b1, 4 + 16'h0028);
		$display("fault done");
	endtask
	task automatic t_hp(input logic dis, input int len, input logic exp);
		cfg.hp_config[4] = dis;
		headphone_select = 1'b0;
		repeat (len) @(posedge clk_sys);
		#1 headphone_select = 1'b1;
		check("hp out", exp, headphone_pwm_out);
		repeat (100) @(posedge clk_sys);
		#1 $display("hp done");
	endtask
	task automatic t_pdn();
		fork
			i_cps_far_side.request_power_down(160);
			begin
				// The request is only taken 160 cycles into the low level.
				repeat (161) @(posedge clk_sys);
				#2 wait_on(0, 1'b0, POWER_DOWN_N + 10);
				check("pdn delay", 1'b1, n >= POWER_DOWN_N - 2 && n <= POWER_DOWN_N + 3);
			end
		join
		repeat (RUN + 20) @(posedge clk_sys);
		#1 check("valid after pdn", 1'b0, power_stage_valid);
		$display("pdn done");
	endtask
	initial
	begin
		repeat (3) @(posedge clk_sys);
		#1 resetn = 1'b1;
		check("valid rst", 1'b0, power_stage_valid);
		wait_on(3, 1'b1, I2C + 10);
		check("i2c delay", 1'b1, n >= I2C - 2 && n <= I2C + 2);
		t_start();
		t_ramp();
		t_fault();
		t_hp(1'b1, 20, 1'b1);
		t_hp(1'b1, 100, 1'b0);
		t_hp(1'b0, 100, 1'b1);
		t_pdn();
		t_start();
		resetn = 1'b0;
		#1 check("valid reset", 1'b0, power_stage_valid);
		print_verdict();
	end
endmodule
